// >>> hdl/pmsq_defs.vh
// Purpose: constants of the power state sequencer
// Assumes: 20 MHz pclk, APB with 32-bit data
// Notes:   offsets are byte addresses
`ifndef PMSQ_DEFS_VH
`define PMSQ_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMSQ_OFS_CTRL      8'h00
`define PMSQ_OFS_WDCFG     8'h04
`define PMSQ_OFS_STATUS    8'h08
`define PMSQ_OFS_IRQ_STAT  8'h0c
`define PMSQ_OFS_IRQ_MASK  8'h10

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define PMSQ_CTRL_STBY_POL  0
`define PMSQ_CTRL_EDGE_MODE 1
`define PMSQ_CTRL_QPU_SEL   2
`define PMSQ_CTRL_XFAIL_EN  3
`define PMSQ_CTRL_OVLO_DIS  4
`define PMSQ_CTRL_W         5
`define PMSQ_CTRL_RST       5'h00
`define PMSQ_WD_W           4
`define PMSQ_WDCFG_RST      4'h3

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define PMSQ_IRQ_PWRUP      0
`define PMSQ_IRQ_WDRST      1
`define PMSQ_IRQ_WDFAULT    2
`define PMSQ_IRQ_IGNORED    3
`define PMSQ_IRQ_W          4

// ----------------------------------------
// states
// ----------------------------------------
`define PMSQ_ST_LOW_POWER_OFF_STATE      3'h0
`define PMSQ_ST_QPU_WAIT    3'h1
`define PMSQ_ST_PWRUP       3'h2
`define PMSQ_ST_RUN         3'h3
`define PMSQ_ST_STANDBY     3'h4
`define PMSQ_ST_WD_RESET    3'h5
`define PMSQ_ST_FAULT_PDN   3'h6

// ----------------------------------------
// timing
// ----------------------------------------
`define PMSQ_CLK_NS         50
`define PMSQ_WD_DLY_NS      30000
`define PMSQ_WD_DLY_CYC     ((`PMSQ_WD_DLY_NS + `PMSQ_CLK_NS - 1) / `PMSQ_CLK_NS)
`define PMSQ_TMR_W          10

`endif

// >>> hdl/pmsq_sync.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to pclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
module pmsq_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ----------------------------------------
  // per-bit chain
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      // reset to zero, the not-ok level of the supply, temperature and fail inputs here
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[g] = out_q;
    end
  endgenerate

endmodule // pmsq_sync

// >>> hdl/pmsq_top.v
// Purpose: top power state sequencer with APB registers
// Assumes: pclk 20 MHz, comparator and pin inputs asynchronous
// Notes:   power tree and turn-off paths live elsewhere
// Summary of operation
// - standby to run when the standby pin differs from the inverted polarity bit sense.
// - run to standby when the pin is high with polarity 0 or low with polarity 1.
// - a hard watchdog reset in run or standby enters the watchdog reset state.
// - watchdog reset returns to run after 30 us if the event count is below the limit.
// - watchdog reset goes to fault power-down when the event count equals the limit.
// - with quick select 1 and test mode low, low-power off passes to the wait state.
// - with test mode high, low-power off passes straight to the wait state.
// - with select 0, a power-up event moves to wait only with good supply, temp, fuses.
// - edge mode bit 0 means a high level, 1 means a high-to-low edge on the power pin.
// - qualification needs vin above undervoltage, below overvoltage unless off, temp ok.
// - wait entered by an event leaves for power up once self-check and fuses pass.
// - with select 1, a fully qualified power-on event leaves the wait state.
// - with test mode high, a fully qualified power-on event leaves the wait state.
// - with the fail enable set, leaving the wait state also needs the fail input high.
// - the quick select bit falls to 0 when vin rises over the undervoltage threshold.
// - a power-up event in low-power off with select 0 and a fuse error is ignored.
`timescale 1ns/10ps
`include "pmsq_defs.vh"
module pmsq_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  input  wire        power_on_request_pin,
  input  wire        standby_pin,
  input  wire        external_fail_input,
  input  wire        test_mode_input,
  input  wire        vin_above_uv,
  input  wire        vin_below_ovlo,
  input  wire        temp_below_tsd,
  input  wire        trim_load_error_flag,
  input  wire        config_fuse_load_error_flag,
  input  wire        self_check_fail_flag,
  input  wire        wd_hard_reset_evt,
  input  wire        pwrup_seq_done,
  input  wire        pdn_seq_done,
  output wire [2:0]  state_o,
  output wire        pwrup_active,
  output wire        run_active,
  output wire        standby_active,
  output wire        wd_reset_active,
  output wire        fault_pdn_active,
  output wire        irq
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [6:0] raw_in;
  wire [6:0] syn;
  assign raw_in = {vin_above_uv, vin_below_ovlo, temp_below_tsd, test_mode_input,
                   external_fail_input, standby_pin, power_on_request_pin};

  pmsq_sync #(.W(7)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  wire pwr_on_s  = syn[0];
  wire stby_s    = syn[1];
  wire xfail_s   = syn[2];
  wire test_s    = syn[3];
  wire tsd_ok_s  = syn[4];
  wire ovlo_ok_s = syn[5];
  wire uv_ok_s   = syn[6];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [`PMSQ_CTRL_W-1:0] ctrl_q;
  reg  [`PMSQ_WD_W-1:0]   wd_limit_q;
  reg  [`PMSQ_WD_W-1:0]   wd_cnt_q;
  reg  [`PMSQ_IRQ_W-1:0]  irq_stat_q;
  reg  [`PMSQ_IRQ_W-1:0]  irq_mask_q;
  reg  [31:0]             prdata_q;
  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg                     from_evt_q;
  reg                     from_evt_d;
  reg  [`PMSQ_TMR_W-1:0]  tmr_q;
  reg                     pwr_prev_q;
  reg                     uv_prev_q;
  reg  [`PMSQ_IRQ_W-1:0]  evt;

  wire stby_pol  = ctrl_q[`PMSQ_CTRL_STBY_POL];
  wire edge_mode = ctrl_q[`PMSQ_CTRL_EDGE_MODE];
  wire qpu_sel   = ctrl_q[`PMSQ_CTRL_QPU_SEL];
  wire xfail_en  = ctrl_q[`PMSQ_CTRL_XFAIL_EN];
  wire ovlo_dis  = ctrl_q[`PMSQ_CTRL_OVLO_DIS];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire mapped = hit(paddr, `PMSQ_OFS_CTRL) | hit(paddr, `PMSQ_OFS_WDCFG) |
                hit(paddr, `PMSQ_OFS_STATUS) | hit(paddr, `PMSQ_OFS_IRQ_STAT) |
                hit(paddr, `PMSQ_OFS_IRQ_MASK);
  wire wr_en  = psel & penable & pwrite;

  // read data captured in setup, so the access phase never waits
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (hit(paddr, `PMSQ_OFS_CTRL)) begin
        prdata_q[`PMSQ_CTRL_W-1:0] <= ctrl_q;
      end
      if (hit(paddr, `PMSQ_OFS_WDCFG)) begin
        prdata_q[`PMSQ_WD_W-1:0] <= wd_limit_q;
      end
      if (hit(paddr, `PMSQ_OFS_STATUS)) begin
        prdata_q[2:0]  <= state_q;
        prdata_q[3]    <= from_evt_q;
        prdata_q[11:8] <= wd_cnt_q;
      end
      if (hit(paddr, `PMSQ_OFS_IRQ_STAT)) begin
        prdata_q[`PMSQ_IRQ_W-1:0] <= irq_stat_q;
      end
      if (hit(paddr, `PMSQ_OFS_IRQ_MASK)) begin
        prdata_q[`PMSQ_IRQ_W-1:0] <= irq_mask_q;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  wire uv_rise = uv_ok_s & ~uv_prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `PMSQ_CTRL_RST;
      wd_limit_q <= `PMSQ_WDCFG_RST;
      irq_mask_q <= {`PMSQ_IRQ_W{1'b0}};
      uv_prev_q  <= 1'b0;
    end else begin
      uv_prev_q <= uv_ok_s;
      if (wr_en & hit(paddr, `PMSQ_OFS_CTRL)) begin
        ctrl_q <= pwdata[`PMSQ_CTRL_W-1:0];
      end
      // supply arrival wins over a write in the same cycle
      if (uv_rise) begin
        ctrl_q[`PMSQ_CTRL_QPU_SEL] <= 1'b0;
      end
      if (wr_en & hit(paddr, `PMSQ_OFS_WDCFG)) begin
        wd_limit_q <= pwdata[`PMSQ_WD_W-1:0];
      end
      if (wr_en & hit(paddr, `PMSQ_OFS_IRQ_MASK)) begin
        irq_mask_q <= pwdata[`PMSQ_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // power-up qualification
  // ----------------------------------------
  wire pwr_fall  = pwr_prev_q & ~pwr_on_s;
  wire pwr_evt   = edge_mode ? pwr_fall : pwr_on_s;
  wire env_ok    = uv_ok_s & (ovlo_dis | ovlo_ok_s) & tsd_ok_s;
  wire fuse_ok   = ~trim_load_error_flag & ~config_fuse_load_error_flag;
  wire check_ok  = fuse_ok & ~self_check_fail_flag;
  wire ext_ok    = ~xfail_en | xfail_s;
  wire qual_evt  = pwr_evt & env_ok & check_ok & ext_ok;
  wire sys_on    = (state_q == `PMSQ_ST_RUN) | (state_q == `PMSQ_ST_STANDBY);
  wire wd_expire = (tmr_q == `PMSQ_WD_DLY_CYC - 1);
  wire wd_at_max = (wd_cnt_q == wd_limit_q);
  wire stby_req  = stby_s ^ stby_pol;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  localparam ST_LOW_POWER_OFF_STATE    = `PMSQ_ST_LOW_POWER_OFF_STATE;
  localparam ST_QPU_WAIT  = `PMSQ_ST_QPU_WAIT;
  localparam ST_PWRUP     = `PMSQ_ST_PWRUP;
  localparam ST_RUN       = `PMSQ_ST_RUN;
  localparam ST_STANDBY   = `PMSQ_ST_STANDBY;
  localparam ST_WD_RESET  = `PMSQ_ST_WD_RESET;
  localparam ST_FAULT_PDN = `PMSQ_ST_FAULT_PDN;

  always @* begin
    state_d    = state_q;
    from_evt_d = from_evt_q;
    evt        = {`PMSQ_IRQ_W{1'b0}};
    case (state_q)
      ST_LOW_POWER_OFF_STATE: begin
        if (test_s) begin
          state_d    = ST_QPU_WAIT;
          from_evt_d = 1'b0;
        end else if (qpu_sel) begin
          state_d    = ST_QPU_WAIT;
          from_evt_d = 1'b0;
        end else if (pwr_evt) begin
          if (!fuse_ok) begin
            evt[`PMSQ_IRQ_IGNORED] = 1'b1;
          end else if (env_ok) begin
            state_d    = ST_QPU_WAIT;
            from_evt_d = 1'b1;
          end
        end
      end
      ST_QPU_WAIT: begin
        if (from_evt_q & ~qpu_sel & ~test_s) begin
          if (check_ok & ext_ok) begin
            state_d = ST_PWRUP;
          end
        end else if (qual_evt) begin
          state_d = ST_PWRUP;
        end
        if (state_d == ST_PWRUP) begin
          evt[`PMSQ_IRQ_PWRUP] = 1'b1;
          from_evt_d           = 1'b0;
        end
      end
      ST_PWRUP: begin
        if (pwrup_seq_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wd_hard_reset_evt) begin
          state_d = ST_WD_RESET;
        end else if (stby_req) begin
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (wd_hard_reset_evt) begin
          state_d = ST_WD_RESET;
        end else if (!stby_req) begin
          state_d = ST_RUN;
        end
      end
      ST_WD_RESET: begin
        if (wd_at_max) begin
          state_d                = ST_FAULT_PDN;
          evt[`PMSQ_IRQ_WDFAULT] = 1'b1;
        end else if (wd_expire) begin
          state_d = ST_RUN;
        end
      end
      ST_FAULT_PDN: begin
        if (pdn_seq_done) begin
          state_d = ST_LOW_POWER_OFF_STATE;
        end
      end
      default: begin
        state_d    = ST_LOW_POWER_OFF_STATE;
        from_evt_d = 1'b0;
      end
    endcase
    if (sys_on & (state_d == ST_WD_RESET)) begin
      evt[`PMSQ_IRQ_WDRST] = 1'b1;
    end
  end

  // ----------------------------------------
  // state, timer and watchdog counter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_LOW_POWER_OFF_STATE;
      from_evt_q <= 1'b0;
      pwr_prev_q <= 1'b0;
      tmr_q      <= {`PMSQ_TMR_W{1'b0}};
      wd_cnt_q   <= {`PMSQ_WD_W{1'b0}};
    end else begin
      state_q    <= state_d;
      from_evt_q <= from_evt_d;
      pwr_prev_q <= pwr_on_s;
      // delay counts only while held in watchdog reset
      if (state_q == ST_WD_RESET) begin
        tmr_q <= tmr_q + 1'b1;
      end else begin
        tmr_q <= {`PMSQ_TMR_W{1'b0}};
      end
      // counter saturates at the limit; cleared once back in off
      if (sys_on & (state_d == ST_WD_RESET) & ~wd_at_max) begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end else if (state_q == ST_LOW_POWER_OFF_STATE) begin
        wd_cnt_q <= {`PMSQ_WD_W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [`PMSQ_IRQ_W-1:0] w1c = (wr_en & hit(paddr, `PMSQ_OFS_IRQ_STAT)) ?
                               pwdata[`PMSQ_IRQ_W-1:0] : {`PMSQ_IRQ_W{1'b0}};

  // a new event beats a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {`PMSQ_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | evt;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------
  // state outputs
  // ----------------------------------------
  assign state_o          = state_q;
  assign pwrup_active     = (state_q == ST_PWRUP);
  assign run_active       = (state_q == ST_RUN);
  assign standby_active   = (state_q == ST_STANDBY);
  assign wd_reset_active  = (state_q == ST_WD_RESET);
  assign fault_pdn_active = (state_q == ST_FAULT_PDN);

endmodule // pmsq_top

// >>> tb/pmsq_properties.sv
// Purpose: port checks of the power state sequencer
// Assumes: control writes are seen on the apb pins
// Notes:   eight samples cover sync stages and the fsm edge
`timescale 1ns/10ps
`include "pmsq_defs.vh"
module pmsq_properties (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        standby_pin,
  input wire        external_fail_input,
  input wire        test_mode_input,
  input wire        wd_hard_reset_evt,
  input wire [2:0]  state_o,
  input wire        pwrup_active,
  input wire        run_active,
  input wire        standby_active,
  input wire        wd_reset_active,
  input wire        fault_pdn_active
);
  reg pol_q;
  reg xen_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q <= 1'h0;
      xen_q <= 1'h0;
    end else if (psel && penable && pwrite && paddr == `PMSQ_OFS_CTRL) begin
      pol_q <= pwdata[`PMSQ_CTRL_STBY_POL];
      xen_q <= pwdata[`PMSQ_CTRL_XFAIL_EN];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence run_lvl;
    (standby_pin == pol_q)[*8];
  endsequence
  // run may be re-entered from wd reset or power up, so those are excluded
  sequence stby_lvl;
    (standby_pin != pol_q && !wd_reset_active && !pwrup_active)[*8];
  endsequence
  sequence fail_low;
    (xen_q && !external_fail_input)[*8];
  endsequence
  stby_exit_a: assert property (run_lvl |-> !standby_active)
    else $error("standby kept against run level");
  stby_entry_a: assert property (stby_lvl |-> !run_active)
    else $error("run kept against standby level");
  wd_entry_a: assert property ((run_active || standby_active) && wd_hard_reset_evt |=> wd_reset_active)
    else $error("watchdog reset not entered");
  wd_exit_a: assert property ($rose(wd_reset_active) |-> ##[1:601] (run_active || fault_pdn_active))
    else $error("watchdog reset never left");
  wd_fault_a: assert property ($rose(fault_pdn_active) |-> $past(wd_reset_active))
    else $error("fault power-down from wrong state");
  sequence tm_rise;
    $rose(test_mode_input) && state_o == `PMSQ_ST_LOW_POWER_OFF_STATE;
  endsequence
  tm_skip_a: assert property (tm_rise |-> ##[1:8] state_o == `PMSQ_ST_QPU_WAIT)
    else $error("test mode did not skip off state");
  wait_exit_a: assert property ($rose(pwrup_active) |-> $past(state_o) == `PMSQ_ST_QPU_WAIT)
    else $error("power up not from wait state");
  fail_gate_a: assert property (fail_low |-> !$rose(pwrup_active))
    else $error("power up with fail input low");
endmodule // pmsq_properties

bind pmsq_top pmsq_properties pmsq_properties_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .standby_pin,
  .external_fail_input, .test_mode_input, .wd_hard_reset_evt, .state_o, .pwrup_active,
  .run_active, .standby_active, .wd_reset_active, .fault_pdn_active
);

// >>> tb/pmsq_host_model.sv
// Purpose: system side finishing the power sequences
// Assumes: sequence done levels are on pclk
// Notes:   dly sets how slowly the rails settle
`timescale 1ns/10ps
module pmsq_host_model #(
  parameter DLY = 5
) (
  input  wire pclk,
  input  wire presetn,
  input  wire pwrup_active,
  input  wire fault_pdn_active,
  input  wire hold_fail,
  output wire external_fail_input,
  output reg  pwrup_seq_done,
  output reg  pdn_seq_done
);
  reg [7:0] cnt_q;
  // system keeps the fail line high unless told to drop it
  assign external_fail_input = hold_fail;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q          <= 8'h00;
      pwrup_seq_done <= 1'h0;
      pdn_seq_done   <= 1'h0;
    end else begin
      cnt_q          <= (pwrup_active || fault_pdn_active) ? cnt_q + 8'h01 : 8'h00;
      pwrup_seq_done <= pwrup_active && cnt_q >= DLY;
      pdn_seq_done   <= fault_pdn_active && cnt_q >= DLY;
    end
  end
endmodule // pmsq_host_model

// >>> tb/tb.sv
// Purpose: self-checking bench of the power state sequencer
// Assumes: pmsq_top beside a behavioural system model
// Notes:   watchdog waits run full length, about 1200 cycles
`timescale 1ns/10ps
`include "pmsq_defs.vh"
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); \
    end \
  end
module tb;
  reg         pclk, presetn, psel, penable, pwrite, err_q, hold_fail;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd_q;
  reg         power_on_request_pin, standby_pin, test_mode_input, wd_hard_reset_evt;
  reg         vin_above_uv, vin_below_ovlo, temp_below_tsd;
  reg         trim_load_error_flag, config_fuse_load_error_flag, self_check_fail_flag;
  wire        pready, pslverr, irq, external_fail_input, pwrup_seq_done, pdn_seq_done;
  wire        pwrup_active, run_active, standby_active, wd_reset_active, fault_pdn_active;
  wire [31:0] prdata;
  wire [2:0]  state_o;
  int         failures, total_checks;
  pmsq_top pmsq_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .power_on_request_pin, .standby_pin, .external_fail_input, .test_mode_input,
    .vin_above_uv, .vin_below_ovlo, .temp_below_tsd, .trim_load_error_flag,
    .config_fuse_load_error_flag, .self_check_fail_flag, .wd_hard_reset_evt,
    .pwrup_seq_done, .pdn_seq_done, .state_o, .pwrup_active, .run_active,
    .standby_active, .wd_reset_active, .fault_pdn_active, .irq
  );
  pmsq_host_model #(.DLY(5)) pmsq_host_model_i (
    .pclk, .presetn, .pwrup_active, .fault_pdn_active, .hold_fail,
    .external_fail_input, .pwrup_seq_done, .pdn_seq_done
  );
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict;
  end
  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wait_st(input reg [2:0] s, input int n);
    int i;
    for (i = 0; i < n && state_o !== s; i++) @(negedge pclk);
    `CHK(state_o, s)
  endtask
  task hold_st(input reg [2:0] s, input int n);
    repeat (n) @(negedge pclk);
    `CHK(state_o, s)
  endtask
  task rst;
    @(posedge pclk);
    power_on_request_pin <= 1'h0;
    standby_pin <= 1'h0;
    test_mode_input <= 1'h0;
    wd_hard_reset_evt <= 1'h0;
    vin_above_uv <= 1'h1;
    vin_below_ovlo <= 1'h1;
    temp_below_tsd <= 1'h1;
    trim_load_error_flag <= 1'h0;
    config_fuse_load_error_flag <= 1'h0;
    self_check_fail_flag <= 1'h0;
    hold_fail <= 1'h1;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
  endtask
  task s_regs;
    apb(1'h0, `PMSQ_OFS_CTRL, 32'h0);
    `CHK(rd_q, {27'h0, `PMSQ_CTRL_RST})
    apb(1'h0, `PMSQ_OFS_WDCFG, 32'h0);
    `CHK(rd_q, {28'h0, `PMSQ_WDCFG_RST})
    apb(1'h0, `PMSQ_OFS_IRQ_MASK, 32'h0);
    `CHK(rd_q, 32'h0)
    apb(1'h0, 8'h40, 32'h0);
    `CHK(err_q, 1'h1)
    `CHK(rd_q, 32'h0)
  endtask
  task s_lpoff;
    @(posedge pclk);
    config_fuse_load_error_flag <= 1'h1;
    power_on_request_pin <= 1'h1;
    hold_st(`PMSQ_ST_LOW_POWER_OFF_STATE, 20);
    apb(1'h0, `PMSQ_OFS_IRQ_STAT, 32'h0);
    `CHK(rd_q[`PMSQ_IRQ_IGNORED], 1'h1)
    `CHK(irq, 1'h0)
    power_on_request_pin <= 1'h0;
    // fuse error kept until the dropped pin has crossed the synchroniser
    repeat (8) @(posedge pclk);
    config_fuse_load_error_flag <= 1'h0;
    apb(1'h1, `PMSQ_OFS_IRQ_MASK, 32'h8);
    @(negedge pclk);
    `CHK(irq, 1'h1)
    apb(1'h1, `PMSQ_OFS_IRQ_STAT, 32'h8);
    @(negedge pclk);
    `CHK(irq, 1'h0)
    @(posedge pclk);
    temp_below_tsd <= 1'h0;
    power_on_request_pin <= 1'h1;
    hold_st(`PMSQ_ST_LOW_POWER_OFF_STATE, 20);
    @(posedge pclk);
    temp_below_tsd <= 1'h1;
    vin_below_ovlo <= 1'h0;
    hold_st(`PMSQ_ST_LOW_POWER_OFF_STATE, 20);
    apb(1'h1, `PMSQ_OFS_CTRL, 32'h10);
    wait_st(`PMSQ_ST_QPU_WAIT, 20);
    wait_st(`PMSQ_ST_RUN, 30);
    apb(1'h0, `PMSQ_OFS_IRQ_STAT, 32'h0);
    `CHK(rd_q[`PMSQ_IRQ_PWRUP], 1'h1)
  endtask
  task s_stby;
    @(posedge pclk);
    standby_pin <= 1'h1;
    wait_st(`PMSQ_ST_STANDBY, 10);
    `CHK(standby_active, 1'h1)
    @(posedge pclk);
    standby_pin <= 1'h0;
    wait_st(`PMSQ_ST_RUN, 10);
    apb(1'h1, `PMSQ_OFS_CTRL, 32'h11);
    wait_st(`PMSQ_ST_STANDBY, 10);
    @(posedge pclk);
    standby_pin <= 1'h1;
    wait_st(`PMSQ_ST_RUN, 10);
  endtask
  task s_wd;
    reg [3:0] k;
    int n;
    for (k = 4'h1; k <= 4'h3; k++) begin
      @(posedge pclk);
      wd_hard_reset_evt <= 1'h1;
      @(posedge pclk);
      wd_hard_reset_evt <= 1'h0;
      wait_st(`PMSQ_ST_WD_RESET, 3);
      `CHK(wd_reset_active, 1'h1)
      if (k < 4'h3) begin
        n = 0;
        while (wd_reset_active === 1'h1 && n < 700) begin
          @(negedge pclk);
          n++;
        end
        `CHK(n, `PMSQ_WD_DLY_CYC)
        `CHK(run_active, 1'h1)
        apb(1'h0, `PMSQ_OFS_STATUS, 32'h0);
        `CHK(rd_q[11:8], k)
      end else begin
        wait_st(`PMSQ_ST_FAULT_PDN, 3);
        `CHK(fault_pdn_active, 1'h1)
        apb(1'h0, `PMSQ_OFS_IRQ_STAT, 32'h0);
        `CHK(rd_q[`PMSQ_IRQ_WDFAULT], 1'h1)
        `CHK(rd_q[`PMSQ_IRQ_WDRST], 1'h1)
      end
    end
  endtask
  task s_tm;
    rst;
    test_mode_input <= 1'h1;
    wait_st(`PMSQ_ST_QPU_WAIT, 10);
    apb(1'h1, `PMSQ_OFS_CTRL, 32'h02);
    power_on_request_pin <= 1'h1;
    hold_st(`PMSQ_ST_QPU_WAIT, 10);
    @(posedge pclk);
    power_on_request_pin <= 1'h0;
    wait_st(`PMSQ_ST_PWRUP, 10);
    `CHK(pwrup_active, 1'h1)
  endtask
  task s_qsel;
    rst;
    vin_above_uv <= 1'h0;
    apb(1'h1, `PMSQ_OFS_CTRL, 32'h0c);
    wait_st(`PMSQ_ST_QPU_WAIT, 10);
    @(posedge pclk);
    vin_above_uv <= 1'h1;
    repeat (8) @(posedge pclk);
    apb(1'h0, `PMSQ_OFS_CTRL, 32'h0);
    `CHK(rd_q[`PMSQ_CTRL_QPU_SEL], 1'h0)
    apb(1'h1, `PMSQ_OFS_CTRL, 32'h0c);
    wait_st(`PMSQ_ST_QPU_WAIT, 10);
    @(posedge pclk);
    hold_fail <= 1'h0;
    power_on_request_pin <= 1'h1;
    hold_st(`PMSQ_ST_QPU_WAIT, 20);
    @(posedge pclk);
    hold_fail <= 1'h1;
    wait_st(`PMSQ_ST_PWRUP, 15);
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst;
    s_regs;
    s_lpoff;
    s_stby;
    s_wd;
    s_tm;
    s_qsel;
    give_verdict;
  end
endmodule // tb
